// File: logic/ais_consts.vh
// constants for the converter input and reference selection block
`ifndef AIS_CONSTS_VH
`define AIS_CONSTS_VH

// ==========================================================
// register byte addresses
`define AIS_ADDR_INPUT_SELECT 8'h7c
`define AIS_ADDR_MISC_CONTROL 8'h80
`define AIS_ADDR_STATUS 8'h84
`define AIS_ADDR_RESULT 8'h88

// ==========================================================
// input select fields
`define AIS_REF_HI_BIT 7
`define AIS_REF_LO_BIT 6
`define AIS_JUSTIFY_BIT 5
`define AIS_CHAN_MSB 4
`define AIS_CHAN_LSB 0
`define AIS_INPUT_SELECT_RESET 8'h00

// ==========================================================
// misc control fields
`define AIS_EXT_REF_EN_BIT 0
`define AIS_MISC_CONTROL_RESET 1'b0

// ==========================================================
// status fields
`define AIS_STAT_DONE_BIT 0
`define AIS_STAT_BUSY_BIT 1
`define AIS_STAT_LONG_BIT 2
`define AIS_STAT_PEND_BIT 3
`define AIS_STAT_APPLIED_LSB 8
`define AIS_STAT_APPLIED_MSB 15
`define AIS_STAT_EXT_ACTIVE_BIT 16

// ==========================================================
// result layout
`define AIS_RESULT_BITS 10
`define AIS_RESULT_WORD_BITS 16
`define AIS_RESULT_RESET 10'h000

// ==========================================================
// conversion lengths in converter clocks
`define AIS_LONG_CONV_CLKS 5'h19
`define AIS_NORM_CONV_CLKS 5'h0d

`endif

// File: logic/ais_input_select.v
// converter input, reference and justification selection with wishbone register access
`timescale 1ns/1ns
`include "ais_consts.vh"

module ais_input_select (
	// clock, reset and freeze
	input wire mclk,
	input wire rst,
	input wire ce,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// converter core status
	input wire conv_busy,
	input wire conv_done,
	input wire [`AIS_RESULT_BITS-1:0] conv_result,
	// reference selection to the analog side
	output reg ref_sel_supply,
	output reg ref_sel_ext_pin,
	output reg ref_sel_int_1v1,
	output reg ref_sel_int_2v56,
	// channel and gain code to the analog side
	output reg [4:0] channel_gain_select,
	// conversion length in converter clocks
	output reg [4:0] conv_len_clks
);

	// ==========================================================
	// state declarations
	reg [7:0] sel_reg; // programmed input select
	reg [7:0] sel_next;
	reg ext_en_reg; // programmed external reference enable
	reg ext_en_next;
	reg [1:0] ref_act_reg; // reference code in force
	reg [1:0] ref_act_next;
	reg ext_act_reg; // external enable in force
	reg ext_act_next;
	reg [4:0] chan_act_reg; // channel code in force
	reg [4:0] chan_act_next;
	reg long_arm_reg; // next conversion must be long
	reg long_arm_next;
	reg long_run_reg; // running conversion is long
	reg long_run_next;
	reg busy_d_reg; // busy one cycle ago, for start detection
	reg done_flag_reg; // conversion done, sticky
	reg done_flag_next;
	reg [`AIS_RESULT_BITS-1:0] raw_reg; // last raw result
	reg [`AIS_RESULT_BITS-1:0] raw_next;
	reg [31:0] rdata_next;
	reg ack_next;
	reg apply_now; // selections may move into force
	reg ref_changed;
	reg conv_start;
	reg wr_req;
	wire [`AIS_RESULT_WORD_BITS-1:0] result_word;

	// ==========================================================
	// result alignment, follows the programmed justify bit directly
	ais_result_align u_align (
		.raw(raw_reg),
		.left_justify(sel_reg[`AIS_JUSTIFY_BIT]),
		.word(result_word)
	);

	// ==========================================================
	// selection update and conversion tracking
	always @* begin
		sel_next = sel_reg;
		ext_en_next = ext_en_reg;
		ref_act_next = ref_act_reg;
		ext_act_next = ext_act_reg;
		chan_act_next = chan_act_reg;
		long_arm_next = long_arm_reg;
		long_run_next = long_run_reg;
		done_flag_next = done_flag_reg;
		raw_next = raw_reg;
		// a bus write is taken once, on the cycle before it is acknowledged
		wr_req = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
		// software writes
		if (wr_req) begin
			case (wb_adr_i)
				`AIS_ADDR_INPUT_SELECT: begin
					if (wb_sel_i[0]) begin
						sel_next = wb_dat_i[7:0]; // all bits writable
					end
				end
				`AIS_ADDR_MISC_CONTROL: begin
					if (wb_sel_i[0]) begin
						ext_en_next = wb_dat_i[`AIS_EXT_REF_EN_BIT];
					end
				end
				`AIS_ADDR_STATUS: begin
					// write one clears the done flag
					if (wb_sel_i[0] && wb_dat_i[`AIS_STAT_DONE_BIT]) begin
						done_flag_next = 1'b0;
					end
				end
				default: begin
					// unmapped or read-only: write ignored
				end
			endcase
		end
		// idle converter takes new selections at once; a running one only
		// at its completion strobe, so the sample in flight stays clean
		apply_now = ~conv_busy | conv_done;
		ref_changed = 1'b0;
		if (apply_now) begin
			ref_changed = (sel_reg[7:6] != ref_act_reg);
			ref_act_next = sel_reg[7:6];
			ext_act_next = ext_en_reg;
			chan_act_next = sel_reg[`AIS_CHAN_MSB:`AIS_CHAN_LSB];
		end
		// conversion start edge moves the long request onto the run
		conv_start = conv_busy & ~busy_d_reg;
		if (conv_done) begin
			long_run_next = 1'b0;
		end
		if (conv_start) begin
			long_run_next = long_arm_reg;
			long_arm_next = 1'b0;
		end
		// a new reference change wins over the arm being consumed
		if (ref_changed) begin
			long_arm_next = 1'b1;
		end
		// completion latches the result and sets the flag; set wins over clear
		if (conv_done) begin
			raw_next = conv_result;
			done_flag_next = 1'b1;
		end
	end

	// ==========================================================
	// read data mux and acknowledge
	always @* begin
		rdata_next = 32'h0000_0000;
		ack_next = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		case (wb_adr_i)
			`AIS_ADDR_INPUT_SELECT: begin
				rdata_next[7:0] = sel_reg;
			end
			`AIS_ADDR_MISC_CONTROL: begin
				rdata_next[`AIS_EXT_REF_EN_BIT] = ext_en_reg;
			end
			`AIS_ADDR_STATUS: begin
				rdata_next[`AIS_STAT_DONE_BIT] = done_flag_reg;
				rdata_next[`AIS_STAT_BUSY_BIT] = conv_busy;
				rdata_next[`AIS_STAT_LONG_BIT] = long_arm_reg | long_run_reg;
				rdata_next[`AIS_STAT_PEND_BIT] = (sel_reg[7:6] != ref_act_reg) ||
					(sel_reg[4:0] != chan_act_reg) || (ext_en_reg != ext_act_reg);
				rdata_next[`AIS_STAT_APPLIED_MSB:`AIS_STAT_APPLIED_LSB] =
					{ref_act_reg, sel_reg[`AIS_JUSTIFY_BIT], chan_act_reg};
				rdata_next[`AIS_STAT_EXT_ACTIVE_BIT] = ext_act_reg;
			end
			`AIS_ADDR_RESULT: begin
				rdata_next[15:0] = result_word;
			end
			default: begin
				rdata_next = 32'h0000_0000; // unmapped reads as zero
			end
		endcase
	end

	// ==========================================================
	// register stage, frozen while ce is low
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sel_reg <= `AIS_INPUT_SELECT_RESET;
			ext_en_reg <= `AIS_MISC_CONTROL_RESET;
			ref_act_reg <= 2'h0;
			ext_act_reg <= 1'b0;
			chan_act_reg <= 5'h00;
			long_arm_reg <= 1'b0;
			long_run_reg <= 1'b0;
			busy_d_reg <= 1'b0;
			done_flag_reg <= 1'b0;
			raw_reg <= `AIS_RESULT_RESET;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
		end else if (ce) begin
			sel_reg <= sel_next;
			ext_en_reg <= ext_en_next;
			ref_act_reg <= ref_act_next;
			ext_act_reg <= ext_act_next;
			chan_act_reg <= chan_act_next;
			long_arm_reg <= long_arm_next;
			long_run_reg <= long_run_next;
			busy_d_reg <= conv_busy;
			done_flag_reg <= done_flag_next;
			raw_reg <= raw_next;
			wb_dat_o <= rdata_next;
			wb_ack_o <= ack_next;
		end
	end

	// ==========================================================
	// analog side outputs, registered from the next state so they
	// track the selection in force with no extra cycle of lag
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ref_sel_supply <= 1'b1;
			ref_sel_ext_pin <= 1'b0;
			ref_sel_int_1v1 <= 1'b0;
			ref_sel_int_2v56 <= 1'b0;
			channel_gain_select <= 5'h00;
			conv_len_clks <= `AIS_NORM_CONV_CLKS;
		end else if (ce) begin
			// low bit clear: external enable picks pin over supply
			ref_sel_supply <= ~ref_act_next[0] & ~ext_act_next;
			// external enable with low bit set is not a listed code;
			// the pin is chosen so no internal source fights it
			ref_sel_ext_pin <= ext_act_next;
			ref_sel_int_1v1 <= ref_act_next[0] & ~ref_act_next[1] & ~ext_act_next;
			ref_sel_int_2v56 <= ref_act_next[0] & ref_act_next[1] & ~ext_act_next;
			channel_gain_select <= chan_act_next;
			// the core reads this length when it starts a conversion
			if (long_arm_next | long_run_next) begin
				conv_len_clks <= `AIS_LONG_CONV_CLKS;
			end else begin
				conv_len_clks <= `AIS_NORM_CONV_CLKS;
			end
		end
	end

endmodule

// File: logic/ais_result_align.v
// result justification: places the ten-bit result in a sixteen-bit word
`timescale 1ns/1ns
`include "ais_consts.vh"

module ais_result_align (
	// raw result from the converter
	input wire [`AIS_RESULT_BITS-1:0] raw,
	// justification control, one means left
	input wire left_justify,
	// aligned word
	output reg [`AIS_RESULT_WORD_BITS-1:0] word
);

	// ==========================================================
	// alignment
	// pure combinational so a change of the justify bit shows at once
	always @* begin
		if (left_justify) begin
			word = {raw, 6'h00}; // upper ten bits
		end else begin
			word = {6'h00, raw}; // lower ten bits
		end
	end

endmodule

// File: test/ais_conv_model.sv
// behavioural converter core
`timescale 1ns/1ns
module ais_conv_model (
	// clock
	input wire mclk,
	input wire rst,
	// bench control
	input wire start,
	input wire [9:0] res_in,
	input wire [4:0] len,
	// status
	output logic conv_busy,
	output logic conv_done,
	output wire [9:0] conv_result
);
	logic [4:0] cnt;
	logic [9:0] val;
	// result scrambled outside the done pulse
	assign conv_result = conv_done ? val : ~val;
	// runs as long as the block asks, done in last busy cycle
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			conv_busy <= 0;
			conv_done <= 0;
			cnt <= 5'h00;
			val <= 10'h000;
		end else begin
			conv_done <= 0;
			if (start && !conv_busy) begin
				conv_busy <= 1;
				cnt <= len;
				val <= res_in;
			end else if (conv_busy) begin
				cnt <= cnt - 5'h01;
				conv_done <= cnt == 5'h02;
				conv_busy <= cnt != 5'h01;
			end
		end
	end
endmodule

// File: test/ais_input_select_checker.sv
// assertion checker for the input select block
`timescale 1ns/1ns
module ais_chk (
	// clock
	input wire mclk,
	input wire rst,
	input wire ce,
	// bus
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	// converter
	input wire conv_busy,
	input wire conv_done,
	input wire ref_sel_supply,
	input wire ref_sel_ext_pin,
	input wire ref_sel_int_1v1,
	input wire ref_sel_int_2v56,
	input wire [4:0] channel_gain_select,
	input wire [4:0] conv_len_clks
);
	// ==========
	// one domain
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	wire [3:0] refs = {ref_sel_supply, ref_sel_ext_pin, ref_sel_int_1v1, ref_sel_int_2v56};
	wire req = ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h7c;
	// no apply edge while converting
	wire hold = conv_busy && !conv_done;
	property p_ack; req |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_hot; $onehot(refs); endproperty
	a_hot: assert property (p_hot) else $error("reference not one-hot");
	property p_len; conv_len_clks == 5'h19 || conv_len_clks == 5'h0d; endproperty
	a_len: assert property (p_len) else $error("odd length");
	property p_hch; hold |=> $stable(channel_gain_select); endproperty
	a_hch: assert property (p_hch) else $error("channel moved mid-run");
	property p_href; hold |=> $stable(refs); endproperty
	a_href: assert property (p_href) else $error("reference moved mid-run");
	property p_apply; wr ##1 (ce && !conv_busy) ##1 1'b1 |-> channel_gain_select == $past(wb_dat_i[4:0], 2); endproperty
	a_apply: assert property (p_apply) else $error("channel not applied");
	property p_long; $rose(ref_sel_int_1v1) && $past(ref_sel_supply) |-> conv_len_clks == 5'h19; endproperty
	a_long: assert property (p_long) else $error("no long conversion");
	property p_freeze; !ce |=> $stable(wb_ack_o) && $stable(channel_gain_select) && $stable(conv_len_clks); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved with ce low");
	c_wr: cover property (wr);
	c_done: cover property (conv_done);
	c_hi: cover property ($rose(ref_sel_int_2v56));
endmodule

bind ais_input_select ais_chk i_chk (.mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
	.wb_dat_i, .wb_ack_o, .conv_busy, .conv_done, .ref_sel_supply, .ref_sel_ext_pin, .ref_sel_int_1v1,
	.ref_sel_int_2v56, .channel_gain_select, .conv_len_clks);

// File: test/tb_top.sv
// self-checking bench for the input select block
`timescale 1ns/1ns
module tb_top;
	// ==========
	// signals
	logic mclk = 0, rst = 1, ce = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, start = 0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h0;
	logic [9:0] res_in = 10'h000, r, r2;
	logic [4:0] ch;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, conv_busy, conv_done, ref_sel_supply, ref_sel_ext_pin, ref_sel_int_1v1, ref_sel_int_2v56;
	wire [9:0] conv_result;
	wire [4:0] channel_gain_select, conv_len_clks;
	wire [31:0] refs = {28'h0, ref_sel_supply, ref_sel_ext_pin, ref_sel_int_1v1, ref_sel_int_2v56};
	int fail_count = 0, cmp_count = 0, seed = 50231, n;
	logic [32:0] exp_q[$];
	// misc enable, select byte, expected one-hot
	logic [12:0] tbl[5] = '{13'h0008, 13'h1004, 13'h0402, 13'h0c01, 13'h1804};
	ais_input_select i_ais_input_select (.mclk, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
		.wb_dat_i, .wb_dat_o, .wb_ack_o, .conv_busy, .conv_done, .conv_result, .ref_sel_supply, .ref_sel_ext_pin,
		.ref_sel_int_1v1, .ref_sel_int_2v56, .channel_gain_select, .conv_len_clks);
	ais_conv_model i_ais_conv_model (.mclk, .rst, .start, .res_in, .len(conv_len_clks), .conv_busy, .conv_done,
		.conv_result);
	initial forever #10 mclk = ~mclk;
	task compare(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task tally_and_finish;
		// a note left over means an answer never came
		if (exp_q.size() != 0) fail_count++;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// bounded wait: a hang counts and ends the run
	task hang_check(input logic ok);
		if (!ok) begin
			fail_count++;
			$display("MISMATCH at %0t: wait timed out", $time);
			tally_and_finish;
		end
	endtask
	// classic single cycle, held until ack, one idle cycle after
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		exp_q.push_back({!w, e});
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_sel_i <= 4'h1;
		wb_adr_i <= a;
		wb_dat_i <= d;
		n = 0;
		do begin @(posedge mclk); n++; end while (wb_ack_o !== 1'b1 && n < 60);
		hang_check(wb_ack_o === 1'b1);
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge mclk);
	endtask
	task conv(input logic [9:0] v);
		res_in <= v;
		start <= 1;
		@(posedge mclk);
		start <= 0;
		@(posedge mclk);
	endtask
	// one extra edge lets the apply land
	task wait_done;
		n = 0;
		do begin @(posedge mclk); n++; end while (conv_done !== 1'b1 && n < 60);
		hang_check(conv_done === 1'b1);
		@(posedge mclk);
	endtask
	// read watcher: oldest note against the acked data
	always @(posedge mclk) if (wb_ack_o === 1'b1) begin
		if (exp_q.size() == 0) begin
			fail_count++;
			$display("MISMATCH at %0t: unexpected ack", $time);
		end else begin
			if (exp_q[0][32]) compare(wb_dat_o, exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end
	initial begin
		repeat (2) @(posedge mclk);
		rst <= 0;
		@(posedge mclk);
		wb(0, 8'h7c, 0, 0);
		wb(0, 8'h90, 0, 0);
		foreach (tbl[i]) begin
			wb(1, 8'h80, {31'h0, tbl[i][12]}, 0);
			wb(1, 8'h7c, {24'h0, tbl[i][11:4]}, 0);
			compare(refs, {28'h0, tbl[i][3:0]});
		end
		wb(1, 8'h80, 0, 0);
		wb(1, 8'h7c, 32'h40, 0);
		compare(conv_len_clks, 5'h19);
		wb(0, 8'h7c, 0, 32'h40);
		r = 10'($random(seed));
		r2 = 10'($random(seed));
		ch = 5'($random(seed));
		conv(r);
		compare(conv_len_clks, 5'h19);
		wait_done;
		compare(conv_len_clks, 5'h0d);
		// status: done set, applied ref 01 and channel 0, then write-one clear
		wb(0, 8'h84, 0, 32'h0000_4001);
		wb(1, 8'h84, 1, 0);
		wb(0, 8'h84, 0, 32'h0000_4000);
		wb(0, 8'h88, 0, {22'h0, r});
		conv(r2);
		wb(1, 8'h7c, {27'h6, ch}, 0);
		compare({channel_gain_select, refs[3:0]}, 9'h2);
		wait_done;
		compare({channel_gain_select, refs[3:0], conv_len_clks}, {ch, 9'h39});
		conv(r2);
		wb(1, 8'h7c, {27'h7, ch}, 0);
		wb(0, 8'h88, 0, {16'h0, r2, 6'h00});
		wait_done;
		wb(1, 8'h7c, {27'h6, ch}, 0);
		wb(0, 8'h88, 0, {22'h0, r2});
		// freeze: the request must wait until ce returns
		ce <= 0;
		fork
			wb(0, 8'h7c, 0, {24'h0, 3'h6, ch});
			begin
				repeat (4) @(posedge mclk);
				ce <= 1;
			end
		join
		tally_and_finish;
	end
endmodule
